// file: core/tmw_defines.svh
/*
  Constants of the 8-bit timer waveform block: register offsets, field
  positions, count limits and timing figures.
  Assumes inclusion by bare name from the core/ folder.
*/
// Behaviour
// - clear-on-match mode: count clears at compare A
// - compare A unbuffered there; missed match wraps
// - clear-on-match: compare flag set each period
// - toggle action inverts output on every match
// - pin shows output only when direction out
// - toggle period is 2*N*(1+compare) clocks
// - clear-on-match: wrap flag at max to zero
// - fast pwm counts bottom to top, restarts
// - fast pwm clears count one tick after top
// - fast pwm: clear on match, set at bottom
// - action two non-inverted, three inverted pwm
// - fast pwm sets wrap flag at top
// - fast pwm fixed top period N*256 clocks
// - fast pwm extreme compare: spike or constant
// - fast pwm toggle action, buffered compare
// - phase correct counts up then down
// - phase correct holds top one tick, reverses
// - phase correct: clear up-match, set down-match
// - phase correct wrap flag at bottom, N*510 at fixed top
// - phase correct extremes give constant levels
// - leaving max compare gives transition at bottom
// - start above compare still transitions at bottom
// - action zero leaves output unchanged
// - compare flag set on tick after equality
// - pwm compare buffered, others written directly
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TMW_OFS_CONTROL   8'h00
`define TMW_OFS_COUNT     8'h04
`define TMW_OFS_COMPARE_A 8'h08
`define TMW_OFS_FLAGS     8'h0C
`define TMW_OFS_PIN       8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMW_CTL_MODE_LSB   0
`define TMW_CTL_ACTION_LSB 4
`define TMW_CTL_CLKSEL_LSB 8
`define TMW_FLG_COMPARE    0
`define TMW_FLG_WRAP       1
`define TMW_PIN_DIR        0
`define TMW_PIN_DATA       1

// ----------------------------------------
// values
// ----------------------------------------
`define TMW_BOTTOM      8'h00
`define TMW_MAX         8'hFF
`define TMW_CLK_NS      4
`define TMW_PRE_WIDTH   10

`endif

// file: core/tmw_pkg.sv
/*
  Types shared by the timer waveform block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tmw_pkg;
  typedef logic [7:0]  tmw_addr_t;
  typedef logic [15:0] tmw_data_t;
  typedef logic [7:0]  tmw_count_t;

  typedef enum logic [2:0] {
    TMW_MODE_NORMAL   = 3'h0,
    TMW_MODE_PC_FIXED = 3'h1,
    TMW_MODE_CLEAR    = 3'h2,
    TMW_MODE_FAST_FIX = 3'h3,
    TMW_MODE_RSV4     = 3'h4,
    TMW_MODE_PC_CMP   = 3'h5,
    TMW_MODE_RSV6     = 3'h6,
    TMW_MODE_FAST_CMP = 3'h7
  } tmw_mode_t;

  typedef enum logic [1:0] {
    TMW_ACT_NONE   = 2'h0,
    TMW_ACT_TOGGLE = 2'h1,
    TMW_ACT_NONINV = 2'h2,
    TMW_ACT_INV    = 2'h3
  } tmw_action_t;
endpackage : tmw_pkg

// file: core/tmw_prescaler.sv
/*
  Timer tick generator: divides the core clock by 1, 8, 32, 64, 128, 256
  or 1024, or stops.
  Assumes an active-low reset from the top module, asserted asynchronously and released on the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmw_defines.svh"

module tmw_prescaler (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // selection and tick
  input  wire logic [2:0] sel,
  output logic            tick
);
  import tmw_pkg::*;

  logic [`TMW_PRE_WIDTH-1:0] div_count;

  // ----------------------------------------
  // divider mask per selection
  // ----------------------------------------
  function automatic logic [`TMW_PRE_WIDTH-1:0] sel_mask(input logic [2:0] s);
    unique case (s)
      3'h2:    sel_mask = 10'h007;
      3'h3:    sel_mask = 10'h01F;
      3'h4:    sel_mask = 10'h03F;
      3'h5:    sel_mask = 10'h07F;
      3'h6:    sel_mask = 10'h0FF;
      3'h7:    sel_mask = 10'h3FF;
      default: sel_mask = 10'h000;
    endcase
  endfunction : sel_mask

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (sel != 3'h0) && ((div_count & sel_mask(sel)) == sel_mask(sel));
    end
  end
endmodule : tmw_prescaler
`default_nettype wire

// file: core/tmw_top.sv
/*
  8-bit timer waveform generator: clear-on-match, fast pwm and phase
  correct pwm counting, compare and wrap flags, one waveform output pin.
  Assumes a register master on CORE_CLK with one-cycle strobes and an
  external load on the pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmw_defines.svh"

module tmw_top (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  // register port
  input  wire tmw_pkg::tmw_addr_t BUS_ADDR,
  input  wire tmw_pkg::tmw_data_t BUS_WDATA,
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  output var  tmw_pkg::tmw_data_t BUS_RDATA,
  // waveform pin
  output logic                   WAVE_PIN_O,
  output logic                   WAVE_PIN_OE,
  // status levels
  output logic                   COMPARE_A_FLAG,
  output logic                   WRAP_FLAG
);
  import tmw_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  tmw_mode_t   waveform_mode_field;
  tmw_action_t output_action_a_field;
  logic [2:0]  clock_select;
  tmw_count_t  count_value;
  tmw_count_t  compare_a_value;
  tmw_count_t  compare_a_buffer;
  logic        compare_a_flag;
  logic        wrap_flag;
  logic        wave_out_a;
  logic        pin_dir;
  logic        pin_data;
  logic        count_up;
  logic        block_match;
  logic        up_match_seen;
  logic        need_fix;
  logic        tick;

  logic        wr_control;
  logic        wr_count;
  logic        wr_compare;
  logic        wr_flags;
  logic        wr_pin;
  logic        is_fast;
  logic        is_pc;
  logic        is_clear;
  tmw_count_t  top_value;
  logic        at_top;
  logic        at_bottom;
  logic        match;
  logic        eff_up;
  logic        fast_wrap;
  logic        pc_turn_top;
  logic        pc_turn_bottom;
  logic        pc_fix;
  tmw_count_t  next_count;

  tmw_prescaler u_prescaler (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .sel   (clock_select),
    .tick  (tick)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input tmw_addr_t a, input tmw_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_control = BUS_WR && hit(BUS_ADDR, `TMW_OFS_CONTROL);
  assign wr_count   = BUS_WR && hit(BUS_ADDR, `TMW_OFS_COUNT);
  assign wr_compare = BUS_WR && hit(BUS_ADDR, `TMW_OFS_COMPARE_A);
  assign wr_flags   = BUS_WR && hit(BUS_ADDR, `TMW_OFS_FLAGS);
  assign wr_pin     = BUS_WR && hit(BUS_ADDR, `TMW_OFS_PIN);

  assign is_fast  = (waveform_mode_field == TMW_MODE_FAST_FIX) ||
                    (waveform_mode_field == TMW_MODE_FAST_CMP);
  assign is_pc    = (waveform_mode_field == TMW_MODE_PC_FIXED) ||
                    (waveform_mode_field == TMW_MODE_PC_CMP);
  assign is_clear = (waveform_mode_field == TMW_MODE_CLEAR);

  // top is compare A in modes 2, 5 and 7, else fixed max
  assign top_value = ((waveform_mode_field == TMW_MODE_CLEAR) ||
                      (waveform_mode_field == TMW_MODE_PC_CMP) ||
                      (waveform_mode_field == TMW_MODE_FAST_CMP)) ?
                     compare_a_value : `TMW_MAX;
  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == `TMW_BOTTOM);
  // equality acts on the tick that ends the matching cycle
  assign match     = tick && !block_match && !wr_count &&
                     (count_value == compare_a_value);
  // a match at top counts as down, at bottom as up
  assign eff_up    = at_bottom ? 1'b1 : (at_top ? 1'b0 : count_up);
  assign fast_wrap      = tick && is_fast && at_top && !wr_count;
  assign pc_turn_top    = tick && is_pc && count_up && at_top && !wr_count;
  assign pc_turn_bottom = tick && is_pc && !count_up && at_bottom && !wr_count;
  assign pc_fix         = pc_turn_bottom && need_fix && (compare_a_value != top_value);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      waveform_mode_field   <= TMW_MODE_NORMAL;
      output_action_a_field <= TMW_ACT_NONE;
      clock_select          <= 3'h0;
    end else if (wr_control) begin
      waveform_mode_field   <= tmw_mode_t'(BUS_WDATA[`TMW_CTL_MODE_LSB +: 3]);
      output_action_a_field <= tmw_action_t'(BUS_WDATA[`TMW_CTL_ACTION_LSB +: 2]);
      clock_select          <= BUS_WDATA[`TMW_CTL_CLKSEL_LSB +: 3];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_dir  <= 1'b0;
      pin_data <= 1'b0;
    end else if (wr_pin) begin
      pin_dir  <= BUS_WDATA[`TMW_PIN_DIR];
      pin_data <= BUS_WDATA[`TMW_PIN_DATA];
    end
  end

  // ----------------------------------------
  // compare register and its buffer
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_buffer <= 8'h00;
    end else if (wr_compare) begin
      compare_a_buffer <= BUS_WDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value <= 8'h00;
    end else if (!is_fast && !is_pc) begin
      if (wr_compare) begin
        compare_a_value <= BUS_WDATA[7:0];
      end else begin
        compare_a_value <= compare_a_buffer;
      end
    end else if (fast_wrap || pc_turn_top) begin
      compare_a_value <= compare_a_buffer;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_comb begin
    next_count = count_value;
    if (is_clear) begin
      next_count = at_top ? `TMW_BOTTOM : count_value + 8'h01;
    end else if (is_fast) begin
      next_count = at_top ? `TMW_BOTTOM : count_value + 8'h01;
    end else if (is_pc) begin
      if (count_up) begin
        next_count = at_top ? count_value - 8'(!at_bottom) : count_value + 8'h01;
      end else begin
        next_count = at_bottom ? count_value + 8'h01 : count_value - 8'h01;
      end
    end else begin
      next_count = count_value + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= 8'h00;
    end else if (wr_count) begin
      count_value <= BUS_WDATA[7:0];
    end else if (tick) begin
      count_value <= next_count;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      count_up <= 1'b1;
    end else if (!is_pc) begin
      count_up <= 1'b1;
    end else if (pc_turn_top && !at_bottom) begin
      count_up <= 1'b0;
    end else if (pc_turn_bottom) begin
      count_up <= 1'b1;
    end
  end

  // a count write hides the next tick's match
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_flag <= 1'b0;
    end else if (match) begin
      compare_a_flag <= 1'b1;
    end else if (wr_flags && BUS_WDATA[`TMW_FLG_COMPARE]) begin
      compare_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag <= 1'b0;
    end else if (tick && !wr_count && !is_fast && !is_pc &&
                 count_value == `TMW_MAX) begin
      wrap_flag <= 1'b1;
    end else if (fast_wrap) begin
      wrap_flag <= 1'b1;
    end else if (pc_turn_bottom) begin
      wrap_flag <= 1'b1;
    end else if (wr_flags && BUS_WDATA[`TMW_FLG_WRAP]) begin
      wrap_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // phase correct symmetry tracking
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      up_match_seen <= 1'b0;
      need_fix      <= 1'b0;
    end else if (pc_turn_top) begin
      up_match_seen <= 1'b0;
      need_fix      <= !up_match_seen;
    end else begin
      if (match && eff_up) begin
        up_match_seen <= 1'b1;
      end
      if (pc_turn_bottom) begin
        need_fix <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // waveform output register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wave_out_a <= 1'b0;
    end else begin
      unique case (output_action_a_field)
        TMW_ACT_NONE: begin
          wave_out_a <= wave_out_a;
        end
        TMW_ACT_TOGGLE: begin
          if (match) begin
            wave_out_a <= !wave_out_a;
          end
        end
        TMW_ACT_NONINV, TMW_ACT_INV: begin
          // inv selects the set level for matches and bottom
          if (is_fast && fast_wrap) begin
            wave_out_a <= (output_action_a_field == TMW_ACT_NONINV);
          end else if (is_pc && pc_fix) begin
            wave_out_a <= (output_action_a_field == TMW_ACT_INV);
          end else if (match && is_pc) begin
            wave_out_a <= eff_up ^ (output_action_a_field == TMW_ACT_NONINV);
          end else if (match) begin
            wave_out_a <= (output_action_a_field == TMW_ACT_INV);
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin and status outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WAVE_PIN_O  <= 1'b0;
      WAVE_PIN_OE <= 1'b0;
    end else begin
      WAVE_PIN_O  <= (output_action_a_field != TMW_ACT_NONE) ? wave_out_a : pin_data;
      WAVE_PIN_OE <= pin_dir;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      COMPARE_A_FLAG <= 1'b0;
      WRAP_FLAG      <= 1'b0;
    end else begin
      COMPARE_A_FLAG <= compare_a_flag;
      WRAP_FLAG      <= wrap_flag;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_RDATA <= 16'h0000;
    end else if (!BUS_RD) begin
      BUS_RDATA <= 16'h0000;
    end else begin
      unique case (BUS_ADDR)
        `TMW_OFS_CONTROL:   BUS_RDATA <= {5'h00, clock_select, 2'h0,
                                          output_action_a_field, 1'b0,
                                          waveform_mode_field};
        `TMW_OFS_COUNT:     BUS_RDATA <= {8'h00, count_value};
        `TMW_OFS_COMPARE_A: BUS_RDATA <= {8'h00, compare_a_buffer};
        `TMW_OFS_FLAGS:     BUS_RDATA <= {14'h0000, wrap_flag, compare_a_flag};
        `TMW_OFS_PIN:       BUS_RDATA <= {14'h0000, pin_data, pin_dir};
        default:            BUS_RDATA <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_clear_at_match;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (tick && is_clear && !wr_count && count_value == compare_a_value) |=> (count_value == 8'h00);
  endproperty
  a_clear_at_match: assert property (p_clear_at_match) else $error("count not cleared at match");

  property p_flag_after_match;
    @(posedge CORE_CLK) disable iff (!rst_n)
    match |=> compare_a_flag ##1 COMPARE_A_FLAG;
  endproperty
  a_flag_after_match: assert property (p_flag_after_match) else $error("compare flag missing");

  property p_toggle_on_match;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (match && output_action_a_field == TMW_ACT_TOGGLE) |=> (wave_out_a != $past(wave_out_a));
  endproperty
  a_toggle_on_match: assert property (p_toggle_on_match) else $error("no toggle on match");

  property p_pin_direction;
    @(posedge CORE_CLK) disable iff (!rst_n)
    ##1 (WAVE_PIN_OE == $past(pin_dir));
  endproperty
  a_pin_direction: assert property (p_pin_direction) else $error("pin enable wrong");

  property p_fast_restart;
    @(posedge CORE_CLK) disable iff (!rst_n)
    fast_wrap |=> (count_value == 8'h00) && wrap_flag;
  endproperty
  a_fast_restart: assert property (p_fast_restart) else $error("fast pwm restart wrong");

  property p_pc_turn;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (pc_turn_top && count_value != 8'h00 && !wr_control) |=> !count_up &&
      (count_value == $past(count_value) - 8'h01);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase turn at top wrong");

  property p_pc_wrap;
    @(posedge CORE_CLK) disable iff (!rst_n)
    pc_turn_bottom |=> wrap_flag && count_up;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("phase wrap flag missing");

  property p_fast_set_bottom;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (fast_wrap && output_action_a_field == TMW_ACT_NONINV) |=> wave_out_a;
  endproperty
  a_fast_set_bottom: assert property (p_fast_set_bottom) else $error("no set at bottom");

  property p_buffer_hold;
    @(posedge CORE_CLK) disable iff (!rst_n)
    ((is_fast || is_pc) && !fast_wrap && !pc_turn_top && !wr_control) |=> $stable(compare_a_value);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("compare changed mid period");

  property p_none_holds;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (output_action_a_field == TMW_ACT_NONE && !wr_control) |=> $stable(wave_out_a);
  endproperty
  a_none_holds: assert property (p_none_holds) else $error("output moved with no action");

  c_clear_match: cover property (@(posedge CORE_CLK) disable iff (!rst_n) match && is_clear);
  c_fast_wrap:   cover property (@(posedge CORE_CLK) disable iff (!rst_n) fast_wrap);
  c_pc_fix:      cover property (@(posedge CORE_CLK) disable iff (!rst_n) pc_fix);
endmodule : tmw_top
`default_nettype wire

// file: test/tmw_load.sv
/*
  Load on the waveform pin: resolves the pin level and counts high
  cycles and rising edges for the bench.
  Assumes the pin is pulled low by the load while not driven.
*/
`timescale 1ns/1ps
`default_nettype none

module tmw_load (
  // clock
  input  wire logic clk,
  // pin and measurement control
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic clr,
  output logic      level,
  output var int    n_high,
  output var int    n_rise
);
  logic last = 1'b0;

  // an undriven pin sits at the pull-down level
  assign level = pin_oe ? pin_o : 1'b0;

  always @(posedge clk) begin
    if (clr) begin
      n_high <= 0;
      n_rise <= 0;
    end else begin
      if (level === 1'b1) n_high <= n_high + 1;
      if (level === 1'b1 && last !== 1'b1) n_rise <= n_rise + 1;
    end
    last <= level;
  end
endmodule : tmw_load

`default_nettype wire

// file: test/tb.sv
/*
  Self-checking bench for the timer waveform block.
  Assumes the core/ files and test/tmw_load.sv are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmw_defines.svh"

module tb;
  import tmw_pkg::*;
  logic      clk   = 1'b0;
  logic      rst_n = 1'b0;
  tmw_addr_t addr  = 8'h00;
  tmw_data_t wdata = 16'h0000;
  logic      wr_s  = 1'b0;
  logic      rd_s  = 1'b0;
  logic      clr   = 1'b0;
  tmw_data_t rdata;
  logic      pin_o, pin_oe, cmp_f, wrap_f, level;
  int        n_high, n_rise;
  int        n_fail = 0, samples_checked = 0, seed = 85;

  always #2 clk = ~clk;

  tmw_top tmw_top_i (.CORE_CLK(clk), .RST_N(rst_n), .BUS_ADDR(addr), .BUS_WDATA(wdata),
    .BUS_WR(wr_s), .BUS_RD(rd_s), .BUS_RDATA(rdata), .WAVE_PIN_O(pin_o),
    .WAVE_PIN_OE(pin_oe), .COMPARE_A_FLAG(cmp_f), .WRAP_FLAG(wrap_f));
  tmw_load tmw_load_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .clr(clr),
    .level(level), .n_high(n_high), .n_rise(n_rise));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input tmw_data_t got, input tmw_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic wr(input tmw_addr_t a, input tmw_data_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rdck(input tmw_addr_t a, input tmw_data_t exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rdck

  function automatic tmw_data_t ctl(input int m, input int a, input int s);
    return tmw_data_t'((m << `TMW_CTL_MODE_LSB) | (a << `TMW_CTL_ACTION_LSB)
      | (s << `TMW_CTL_CLKSEL_LSB));
  endfunction : ctl

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  // reads the count every cycle and steps the model alongside it
  task automatic seq(input int k, input int top, input bit pc);
    int p, dir;
    @(posedge clk);
    addr <= `TMW_OFS_COUNT;
    rd_s <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    p   = int'(rdata[7:0]);
    dir = 1;
    repeat (k) begin
      if (pc && p == top) dir = -1;
      if (pc && p == 0) dir = 1;
      p = pc ? p + dir : ((p == top || p == 255) ? 0 : p + 1);
      @(negedge clk);
      chk(rdata, tmw_data_t'(p));
    end
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : seq

  // high cycles per period of a pwm output
  function automatic int hi_of(input int m, input int a, input int c);
    int h;
    h = (m == 1) ? 2 * c : ((c == 255) ? 256 : c + 1);
    return (a == 3) ? ((m == 1) ? 510 : 256) - h : h;
  endfunction : hi_of

  // settles a waveform, then measures two whole periods at the load
  task automatic duty(input tmw_data_t cw, input int c, input int per, input int hi);
    wr(`TMW_OFS_CONTROL, cw);
    wr(`TMW_OFS_COMPARE_A, tmw_data_t'(c));
    repeat (2 * per + 20) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2 * per) @(posedge clk);
    @(negedge clk);
    chk(tmw_data_t'(n_high), tmw_data_t'(2 * hi));
    chk(tmw_data_t'(n_rise), tmw_data_t'((hi > 0 && hi < per) ? 2 : 0));
  endtask : duty

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin : main
    int m, a, i, c;
    int cs [4];
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdck(`TMW_OFS_COUNT, 16'h0000);
    rdck(8'h14, 16'h0000);
    wr(`TMW_OFS_COMPARE_A, 16'h0030);
    wr(`TMW_OFS_CONTROL, ctl(2, 0, 1));
    rdck(`TMW_OFS_CONTROL, ctl(2, 0, 1));
    seq(120, 48, 1'b0);
    wr(`TMW_OFS_FLAGS, 16'h0003);
    wr(`TMW_OFS_COUNT, 16'h0020);
    wr(`TMW_OFS_COMPARE_A, 16'h0005);
    seq(300, 5, 1'b0);
    @(negedge clk);
    chk(wrap_f, 1'b1);
    wr(`TMW_OFS_FLAGS, 16'h0003);
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk(cmp_f, 1'b1);
    chk(wrap_f, 1'b0);
    wr(`TMW_OFS_COMPARE_A, 16'h0020);
    wr(`TMW_OFS_CONTROL, ctl(7, 2, 1));
    seq(100, 32, 1'b0);
    wr(`TMW_OFS_FLAGS, 16'h0003);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(wrap_f, 1'b1);
    wr(`TMW_OFS_CONTROL, ctl(5, 2, 1));
    seq(150, 32, 1'b1);
    wr(`TMW_OFS_FLAGS, 16'h0003);
    repeat (70) @(posedge clk);
    @(negedge clk);
    chk(wrap_f, 1'b1);
    wr(`TMW_OFS_PIN, 16'h0003);
    cs = '{0, 128, 255, 0};
    cs[3] = $random(seed) & 255;
    for (m = 1; m <= 3; m += 2) begin
      for (a = 2; a <= 3; a++) begin
        for (i = 0; i < 4; i++) begin
          duty(ctl(m, a, 1), cs[i], (m == 1) ? 510 : 256, hi_of(m, a, cs[i]));
        end
      end
    end
    duty(ctl(3, 1, 1), cs[3], 512, 256);
    wr(`TMW_OFS_CONTROL, ctl(2, 0, 2));
    wr(`TMW_OFS_COUNT, 16'h0000);
    // the count write hides the match at zero, so compare starts at one
    c = ($random(seed) & 15) + 1;
    duty(ctl(2, 1, 2), c, 16 * (c + 1), 8 * (c + 1));
    duty(ctl(3, 0, 1), 5, 256, 256);
    wr(`TMW_OFS_PIN, 16'h0001);
    duty(ctl(3, 0, 1), 5, 256, 0);
    wr(`TMW_OFS_PIN, 16'h0002);
    duty(ctl(3, 2, 1), 128, 256, 0);
    chk(pin_oe, 1'b0);
    close_out();
  end
endmodule : tb

`default_nettype wire
